// ===== pkg/dcr_ce_if.sv
// carrier for the divided clock enable between top and divider
`timescale 1ns/100ps
interface dcr_ce_if #(
  parameter int W = 4
);
  logic [W-1:0] ratio;
  logic         ce;

  modport gen (
    input  ratio,
    output ce
  );

  modport ctl (
    output ratio,
    input  ce
  );
endinterface

// ===== pkg/dcr_pkg.sv
// shared constants and types for the debug clock and reset distribution
package dcr_pkg;

  // ****************************************************************
  // reference clock
  // ****************************************************************
  localparam int REF_CLK_HZ        = 25_000_000;
  localparam int REF_CLK_PERIOD_NS = 1_000_000_000 / REF_CLK_HZ;

  // ****************************************************************
  // synchronizers and dividers
  // ****************************************************************
  localparam int SYNC_STAGES       = 2;
  localparam int DIV_W             = 4;
  localparam int CROSS_W           = 4;
  localparam int N_TRIG_IF         = 3;

  // ****************************************************************
  // scan chain reset pulse, least time rounds up
  // ****************************************************************
  localparam int SCAN_HOLD_NS      = 400;
  localparam int SCAN_HOLD_CYC     =
    (SCAN_HOLD_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
  localparam int SCAN_CNT_W        = 8;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic RST_ASSERTED    = 1'b0;
  localparam logic RST_RELEASED    = 1'b1;
  localparam logic CE_RST          = 1'b0;
  localparam logic STRAP_RST       = 1'b0;
  localparam logic [SCAN_CNT_W-1:0] SCAN_CNT_RST = 8'h00;

  // ****************************************************************
  // scan chain reset sequencer
  // ****************************************************************
  typedef enum logic [1:0] {
    dcr_scan_idle = 2'b00,
    dcr_scan_hold = 2'b01,
    dcr_scan_wait = 2'b10
  } dcr_scan_state_t;

endpackage

// ===== rtl/dcr_clk_en.sv
// clock enable divider on the reference clock
`timescale 1ns/100ps
module dcr_clk_en
  import dcr_pkg::*;
#(
  parameter int W = DIV_W
) (
  input  wire logic clk,
  input  wire logic rst_n,
  dcr_ce_if.gen     ce_port
);

  localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

  logic [W-1:0] cnt;
  logic         wrap;

  if (W < 1) begin : g_bad_width
    $error("dcr_clk_en needs a ratio of at least one bit");
  end

  // ratio 0 is served as 1 so the bus never stalls for good
  assign wrap = (ce_port.ratio <= ONE) || (cnt >= ce_port.ratio - ONE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (wrap) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ce_port.ce <= CE_RST;
    end else begin
      ce_port.ce <= wrap;
    end
  end

endmodule // dcr_clk_en

// ===== rtl/dcr_rst_sync.sv
// reset synchronizer: asynchronous assert, synchronous release
`timescale 1ns/100ps
module dcr_rst_sync
  import dcr_pkg::*;
#(
  parameter int STAGES = SYNC_STAGES
) (
  input  wire logic clk,
  input  wire logic arst_n,
  output logic      rst_n
);

  logic [STAGES-1:0] chain;

  if (STAGES < 2) begin : g_bad_stages
    $error("dcr_rst_sync needs at least two stages");
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chain <= '0;
    end else begin
      chain <= {chain[STAGES-2:0], RST_RELEASED};
    end
  end

  assign rst_n = chain[STAGES-1];

endmodule // dcr_rst_sync

// ===== rtl/dcr_top.sv
// debug and trace clock and reset distribution
`timescale 1ns/100ps
// Function
// - access port internal clock is the debug bus clock itself
// - debug bus clock synchronous to trace clock, never faster
// - slower debug bus uses trace clock plus derived clock enable
// - clock enables of domains needing none are tied high
// - trace bus reset active low, clears whole trace clock domain
// - trigger interface and matrix resets active low, own domains
// - debug bus reset active low, clears debug bus clock domain
// - trace, debug bus and access port resets share one source
// - debug resets assert asynchronously, release synchronously
// - trace port reset active low, may share trace bus source
// - same trace port clock: reuse trace bus synchronizer output
// - differing trace port clock: separate synchronizer releases it
// - power-on reset low only at platform power-on
// - power-on reset clears port logic except test state machine
// - power-on reset passes through a synchronizer to test clock
// - interconnect reset resets access port, bus port and master
// - bus trace unit reset kept apart from interconnect reset
// - system peripheral reset equals interconnect reset if same clock
// - scan chain access port resets connected test controllers
// - scan chain access port resets associated subsystems too
// - power domain crossings built as asynchronous boundaries
// - system bus to access port signals are synchronized
module dcr_top
  import dcr_pkg::*;
#(
  parameter int STAGES        = SYNC_STAGES,
  parameter int DIV_BITS      = DIV_W,
  parameter int XW            = CROSS_W,
  parameter int N_TRIG        = N_TRIG_IF,
  parameter bit SYS_PCLK_SAME = 1'b1
) (
  input  wire logic                ref_clk,
  input  wire logic                rstn,
  input  wire logic                power_on_reset_n,
  input  wire logic                test_reset_src_n,
  input  wire logic                interconnect_reset_n,
  input  wire logic                bus_trace_src_reset_n,
  input  wire logic                trace_clock_shared,
  input  wire logic [DIV_BITS-1:0] debug_bus_ratio,
  input  wire logic                scan_tap_reset_req,
  input  wire logic                scan_subsys_reset_req,
  input  wire logic [XW-1:0]       sys_to_dap,
  input  wire logic [XW-1:0]       dap_to_sys,
  output logic                     trace_bus_clock,
  output logic                     debug_bus_clock,
  output logic                     access_port_internal_clock,
  output logic                     trigger_interface_clock,
  output logic                     trigger_matrix_clock,
  output logic                     trace_bus_clock_enable,
  output logic                     debug_bus_clock_enable,
  output logic                     trigger_interface_clock_enable,
  output logic                     trigger_matrix_clock_enable,
  output logic                     trace_bus_reset_n,
  output logic                     debug_bus_reset_n,
  output logic                     access_port_reset_n,
  output logic [N_TRIG-1:0]        trigger_interface_reset_n,
  output logic                     trigger_matrix_reset_n,
  output logic                     trace_port_reset_n,
  output logic                     power_on_sync_reset_n,
  output logic                     test_state_machine_reset_n,
  output logic                     access_port_sys_reset_n,
  output logic                     system_peripheral_reset_n,
  output logic                     bus_trace_unit_reset_n,
  output logic                     scan_chain_controller_reset_n,
  output logic                     scan_subsystem_reset_n,
  output logic [XW-1:0]            sys_to_dap_sync,
  output logic [XW-1:0]            dap_to_sys_sync
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (STAGES < 2) begin : g_bad_stages
    $error("dcr_top needs at least two synchronizer stages");
  end
  if (N_TRIG < 1) begin : g_bad_trig
    $error("dcr_top needs at least one trigger interface");
  end
  if (XW < 1) begin : g_bad_cross
    $error("dcr_top needs a crossing of at least one bit");
  end
  if (SCAN_HOLD_CYC >= (1 << SCAN_CNT_W)) begin : g_bad_hold
    $error("scan reset hold does not fit its counter");
  end

  // ****************************************************************
  // clock distribution
  // ****************************************************************
  // every synchronous debug domain runs on the one reference clock,
  // so no skew or phase step can appear between them
  assign trace_bus_clock            = ref_clk;
  assign debug_bus_clock            = ref_clk;
  assign access_port_internal_clock = ref_clk;
  assign trigger_interface_clock    = ref_clk;
  assign trigger_matrix_clock       = ref_clk;

  // domains running at full rate need no gating
  assign trace_bus_clock_enable         = 1'b1;
  assign trigger_interface_clock_enable = 1'b1;
  assign trigger_matrix_clock_enable    = 1'b1;

  // ****************************************************************
  // debug bus clock enable
  // ****************************************************************
  dcr_ce_if #(.W(DIV_BITS)) ce_bus ();

  assign ce_bus.ratio = debug_bus_ratio;

  // the enable is derived on the trace clock, so the debug bus can
  // only run at or below it; faster is not expressible here
  dcr_clk_en #(
    .W       (DIV_BITS)
  ) u_dbg_ce (
    .clk     (ref_clk),
    .rst_n   (debug_bus_reset_n),
    .ce_port (ce_bus)
  );

  assign debug_bus_clock_enable = ce_bus.ce;

  // ****************************************************************
  // shared debug reset: trace bus, debug bus and access port
  // ****************************************************************
  logic dbg_sync_rst_n;

  dcr_rst_sync #(
    .STAGES (STAGES)
  ) u_dbg_sync (
    .clk    (ref_clk),
    .arst_n (rstn),
    .rst_n  (dbg_sync_rst_n)
  );

  // one synchronizer output feeds all three so they leave reset on
  // the same edge; separate ones could release a cycle apart
  assign trace_bus_reset_n   = dbg_sync_rst_n;
  assign debug_bus_reset_n   = dbg_sync_rst_n;
  assign access_port_reset_n = dbg_sync_rst_n;

  // ****************************************************************
  // trigger interface and trigger matrix resets
  // ****************************************************************
  // each trigger interface gets its own synchronizer so that one
  // may later move to an unrelated clock without a shared release
  for (genvar t = 0; t < N_TRIG; t++) begin : g_trig
    dcr_rst_sync #(
      .STAGES (STAGES)
    ) u_trig_sync (
      .clk    (ref_clk),
      .arst_n (rstn),
      .rst_n  (trigger_interface_reset_n[t])
    );
  end

  dcr_rst_sync #(
    .STAGES (STAGES)
  ) u_matrix_sync (
    .clk    (ref_clk),
    .arst_n (rstn),
    .rst_n  (trigger_matrix_reset_n)
  );

  // ****************************************************************
  // trace port reset
  // ****************************************************************
  logic tp_sync_rst_n;
  logic strap_taken;
  logic trace_shared;

  // the strap is sampled once after release; a change later on is
  // ignored so the reset source cannot flip under running logic
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      strap_taken  <= STRAP_RST;
      trace_shared <= STRAP_RST;
    end else if (!strap_taken) begin
      strap_taken  <= 1'b1;
      trace_shared <= trace_clock_shared;
    end
  end

  dcr_rst_sync #(
    .STAGES (STAGES)
  ) u_tport_sync (
    .clk    (ref_clk),
    .arst_n (rstn),
    .rst_n  (tp_sync_rst_n)
  );

  // trace bus synchronizer output when the strap says shared, else u_tport_sync; both assert together
  assign trace_port_reset_n = trace_shared ? dbg_sync_rst_n
                                           : tp_sync_rst_n;

  // ****************************************************************
  // power-on and test resets
  // ****************************************************************
  // only the platform power-on pin may drive this one; the shared
  // debug reset is deliberately kept out of it
  dcr_rst_sync #(
    .STAGES (STAGES)
  ) u_por_sync (
    .clk    (ref_clk),
    .arst_n (power_on_reset_n),
    .rst_n  (power_on_sync_reset_n)
  );

  // the test state machine keeps its own reset, untouched by power-on
  dcr_rst_sync #(
    .STAGES (STAGES)
  ) u_test_sync (
    .clk    (ref_clk),
    .arst_n (test_reset_src_n),
    .rst_n  (test_state_machine_reset_n)
  );

  // ****************************************************************
  // system side resets
  // ****************************************************************
  dcr_rst_sync #(
    .STAGES (STAGES)
  ) u_sys_sync (
    .clk    (ref_clk),
    .arst_n (interconnect_reset_n),
    .rst_n  (access_port_sys_reset_n)
  );

  if (SYS_PCLK_SAME) begin : g_sys_same
    assign system_peripheral_reset_n = access_port_sys_reset_n;
  end else begin : g_sys_own
    dcr_rst_sync #(
      .STAGES (STAGES)
    ) u_speri_sync (
      .clk    (ref_clk),
      .arst_n (interconnect_reset_n),
      .rst_n  (system_peripheral_reset_n)
    );
  end

  // a separate source, so an interconnect reset can itself be traced
  dcr_rst_sync #(
    .STAGES (STAGES)
  ) u_btu_sync (
    .clk    (ref_clk),
    .arst_n (bus_trace_src_reset_n),
    .rst_n  (bus_trace_unit_reset_n)
  );

  // ****************************************************************
  // scan chain reset sequencer
  // ****************************************************************
  dcr_scan_state_t        scan_state;
  logic [SCAN_CNT_W-1:0]  scan_cnt;
  logic                   sel_tap;
  logic                   sel_sub;
  logic                   hold_done;

  localparam logic [SCAN_CNT_W-1:0] HOLD_LAST =
    SCAN_CNT_W'(SCAN_HOLD_CYC - 1);

  assign hold_done = (scan_cnt == HOLD_LAST);

  always_ff @(posedge ref_clk or negedge access_port_reset_n) begin
    if (!access_port_reset_n) begin
      scan_state <= dcr_scan_idle;
    end else begin
      unique case (scan_state)
        dcr_scan_idle: begin
          if (scan_tap_reset_req || scan_subsys_reset_req) begin
            scan_state <= dcr_scan_hold;
          end
        end
        dcr_scan_hold: begin
          if (hold_done) begin
            scan_state <= dcr_scan_wait;
          end
        end
        dcr_scan_wait: begin
          // a request held high must not retrigger endlessly
          if (!scan_tap_reset_req && !scan_subsys_reset_req) begin
            scan_state <= dcr_scan_idle;
          end
        end
        default: begin
          scan_state <= dcr_scan_idle;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge access_port_reset_n) begin
    if (!access_port_reset_n) begin
      scan_cnt <= SCAN_CNT_RST;
    end else if (scan_state == dcr_scan_hold) begin
      scan_cnt <= scan_cnt + SCAN_CNT_W'(1);
    end else begin
      scan_cnt <= SCAN_CNT_RST;
    end
  end

  always_ff @(posedge ref_clk or negedge access_port_reset_n) begin
    if (!access_port_reset_n) begin
      sel_tap <= 1'b0;
      sel_sub <= 1'b0;
    end else if (scan_state == dcr_scan_idle) begin
      sel_tap <= scan_tap_reset_req;
      sel_sub <= scan_subsys_reset_req;
    end
  end

  // both scan resets are held asserted while the port itself is in
  // reset, so no controller leaves reset before its master does
  always_ff @(posedge ref_clk or negedge access_port_reset_n) begin
    if (!access_port_reset_n) begin
      scan_chain_controller_reset_n <= RST_ASSERTED;
    end else begin
      scan_chain_controller_reset_n <=
        !((scan_state == dcr_scan_hold) && sel_tap);
    end
  end

  always_ff @(posedge ref_clk or negedge access_port_reset_n) begin
    if (!access_port_reset_n) begin
      scan_subsystem_reset_n <= RST_ASSERTED;
    end else begin
      scan_subsystem_reset_n <=
        !((scan_state == dcr_scan_hold) && sel_sub);
    end
  end

  // ****************************************************************
  // power domain and system bus crossings
  // ****************************************************************
  // each bit crosses on its own; multi-bit words need a handshake on
  // top, these chains only keep single levels free of metastability
  logic [XW-1:0] s2d_meta;
  logic [XW-1:0] d2s_meta;

  always_ff @(posedge ref_clk or negedge access_port_reset_n) begin
    if (!access_port_reset_n) begin
      s2d_meta        <= '0;
      sys_to_dap_sync <= '0;
    end else begin
      s2d_meta        <= sys_to_dap;
      sys_to_dap_sync <= s2d_meta;
    end
  end

  always_ff @(posedge ref_clk or negedge access_port_sys_reset_n) begin
    if (!access_port_sys_reset_n) begin
      d2s_meta        <= '0;
      dap_to_sys_sync <= '0;
    end else begin
      d2s_meta        <= dap_to_sys;
      dap_to_sys_sync <= d2s_meta;
    end
  end

endmodule // dcr_top

// ===== tb/dcr_chk.sv
// concurrent checks on the ports of the distribution top
`timescale 1ns/100ps
module dcr_chk #(
  parameter int XW     = 4,
  parameter int N_TRIG = 3
) (
  input wire logic              ref_clk,
  input wire logic              rstn,
  input wire logic              power_on_reset_n,
  input wire logic              test_reset_src_n,
  input wire logic              interconnect_reset_n,
  input wire logic              bus_trace_src_reset_n,
  input wire logic              scan_tap_reset_req,
  input wire logic [XW-1:0]     sys_to_dap,
  input wire logic              trace_bus_clock,
  input wire logic              debug_bus_clock,
  input wire logic              access_port_internal_clock,
  input wire logic              trace_bus_clock_enable,
  input wire logic              trigger_matrix_clock_enable,
  input wire logic              trace_bus_reset_n,
  input wire logic              debug_bus_reset_n,
  input wire logic              access_port_reset_n,
  input wire logic [N_TRIG-1:0] trigger_interface_reset_n,
  input wire logic              trigger_matrix_reset_n,
  input wire logic              trace_port_reset_n,
  input wire logic              power_on_sync_reset_n,
  input wire logic              test_state_machine_reset_n,
  input wire logic              access_port_sys_reset_n,
  input wire logic              system_peripheral_reset_n,
  input wire logic              bus_trace_unit_reset_n,
  input wire logic              scan_chain_controller_reset_n,
  input wire logic [XW-1:0]     sys_to_dap_sync
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // ****************************************************************
  // sequences
  // ****************************************************************
  sequence s_rel(r);
    !r ##1 !r ##1 r;
  endsequence
  sequence s_held;
    (!scan_chain_controller_reset_n)[*8] ##1 !scan_chain_controller_reset_n
      ##1 !scan_chain_controller_reset_n ##1 scan_chain_controller_reset_n;
  endsequence

  // ****************************************************************
  // assertions
  // ****************************************************************
  tie_offs_a: assert property (
    debug_bus_clock == access_port_internal_clock &&
    debug_bus_clock == trace_bus_clock && trace_bus_clock_enable &&
    trigger_matrix_clock_enable) else $error("clock tie-off wrong");
  rst_assert_a: assert property (disable iff (1'b0)
    !rstn |-> !trace_bus_reset_n && !trace_port_reset_n &&
    trigger_interface_reset_n == '0 && !trigger_matrix_reset_n)
    else $error("debug reset not asserted");
  rst_release_a: assert property (
    $rose(rstn) |-> s_rel(trace_bus_reset_n))
    else $error("debug reset release timing");
  share_rst_a: assert property (
    debug_bus_reset_n == trace_bus_reset_n &&
    access_port_reset_n == trace_bus_reset_n &&
    trace_port_reset_n == trace_bus_reset_n &&
    trigger_matrix_reset_n == trace_bus_reset_n &&
    trigger_interface_reset_n == {N_TRIG{trace_bus_reset_n}})
    else $error("shared resets differ");
  por_release_a: assert property (disable iff (!power_on_reset_n)
    $rose(power_on_reset_n) |-> s_rel(power_on_sync_reset_n))
    else $error("power-on release timing");
  tsm_apart_a: assert property (
    !power_on_reset_n && test_reset_src_n &&
    $past(test_state_machine_reset_n) |-> test_state_machine_reset_n)
    else $error("test state machine hit by power-on");
  sys_rst_a: assert property (
    system_peripheral_reset_n == access_port_sys_reset_n &&
    (interconnect_reset_n || !access_port_sys_reset_n))
    else $error("interconnect reset wrong");
  btu_apart_a: assert property (
    !interconnect_reset_n && bus_trace_src_reset_n &&
    $past(bus_trace_unit_reset_n) |-> bus_trace_unit_reset_n)
    else $error("bus trace reset follows interconnect");
  scan_take_a: assert property (
    $rose(scan_tap_reset_req) && scan_chain_controller_reset_n
    |-> ##2 !scan_chain_controller_reset_n) else $error("scan take late");
  scan_hold_a: assert property (
    $fell(scan_chain_controller_reset_n) |-> s_held)
    else $error("scan reset hold length");
  xing_a: assert property (
    access_port_reset_n && $past(access_port_reset_n) &&
    $past(access_port_reset_n, 2) |-> sys_to_dap_sync == $past(sys_to_dap, 2))
    else $error("crossing latency");
endmodule // dcr_chk

bind dcr_top dcr_chk #(.XW(XW), .N_TRIG(N_TRIG)) u_chk (.*);

// ===== tb/dcr_sink.sv
// debug component model fed by the distributed clocks and resets
`timescale 1ns/100ps
module dcr_sink (
  input  wire logic       trace_bus_clock,
  input  wire logic       debug_bus_clock_enable,
  input  wire logic       trace_bus_reset_n,
  input  wire logic       debug_bus_reset_n,
  output logic [7:0]      ce_count,
  output logic [7:0]      trace_ticks
);
  // ****************************************************************
  // debug bus side: trace clock on both inputs, paced by the enable
  // ****************************************************************
  always_ff @(posedge trace_bus_clock or negedge debug_bus_reset_n) begin
    if (!debug_bus_reset_n) ce_count <= 8'h00;
    else if (debug_bus_clock_enable) ce_count <= ce_count + 8'h01;
  end

  // ****************************************************************
  // trace bus side: free running register, cleared by its reset
  // ****************************************************************
  always_ff @(posedge trace_bus_clock or negedge trace_bus_reset_n) begin
    if (!trace_bus_reset_n) trace_ticks <= 8'h00;
    else trace_ticks <= trace_ticks + 8'h01;
  end
endmodule // dcr_sink

// ===== tb/dcr_top_tb_top.sv
// self-checking bench for the debug clock and reset distribution
`timescale 1ns/100ps
module dcr_top_tb_top
  import dcr_pkg::*;
;
  logic ref_clk, rstn, power_on_reset_n, test_reset_src_n;
  logic interconnect_reset_n, bus_trace_src_reset_n, trace_clock_shared;
  logic scan_tap_reset_req, scan_subsys_reset_req;
  logic [DIV_W-1:0] debug_bus_ratio;
  logic [CROSS_W-1:0] sys_to_dap, dap_to_sys, sys_to_dap_sync, dap_to_sys_sync;
  logic trace_bus_clock, debug_bus_clock, access_port_internal_clock;
  logic trigger_interface_clock, trigger_matrix_clock, trace_bus_clock_enable;
  logic debug_bus_clock_enable, trigger_interface_clock_enable;
  logic trigger_matrix_clock_enable, trace_bus_reset_n, debug_bus_reset_n;
  logic access_port_reset_n, trigger_matrix_reset_n, trace_port_reset_n;
  logic [N_TRIG_IF-1:0] trigger_interface_reset_n;
  logic power_on_sync_reset_n, test_state_machine_reset_n;
  logic access_port_sys_reset_n, system_peripheral_reset_n;
  logic bus_trace_unit_reset_n, scan_chain_controller_reset_n;
  logic scan_subsystem_reset_n;
  logic [7:0] ce_count, trace_ticks;
  int n_fail, tests_run, cyc;
  localparam logic [3:0] RATIOS [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'hF};

  dcr_top dut (.*);
  dcr_sink u_sink (
    .trace_bus_clock        (trace_bus_clock),
    .debug_bus_clock_enable (debug_bus_clock_enable),
    .trace_bus_reset_n      (trace_bus_reset_n),
    .debug_bus_reset_n      (debug_bus_reset_n),
    .ce_count               (ce_count),
    .trace_ticks            (trace_ticks)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] dbg_rsts();
    return {trace_bus_reset_n, debug_bus_reset_n, access_port_reset_n,
      trigger_matrix_reset_n, trace_port_reset_n, trigger_interface_reset_n};
  endfunction
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_debug_reset(input logic strap);
    #1 check(8'({trace_bus_clock_enable,
      trigger_interface_clock_enable, trigger_matrix_clock_enable,
      debug_bus_clock === trace_bus_clock, trigger_matrix_clock === ref_clk,
      access_port_internal_clock === debug_bus_clock,
      trigger_interface_clock === ref_clk}), 8'h7F);
    @(posedge ref_clk) rstn <= 1'b0;
    trace_clock_shared <= strap;
    #1 check(dbg_rsts(), 8'h00);
    check(trace_ticks, 8'h00);
    @(posedge ref_clk) rstn <= 1'b1;
    #1 check(dbg_rsts(), 8'h00);
    @(posedge ref_clk) #1 check(dbg_rsts(), 8'h00);
    @(posedge ref_clk) #1 check(dbg_rsts(), 8'hFF);
  endtask

  task automatic t_ratio();
    logic [7:0] c0;
    int n;
    foreach (RATIOS[i]) begin
      @(posedge ref_clk) debug_bus_ratio <= RATIOS[i];
      n = (RATIOS[i] < 4'h2) ? 6 : 6 * int'(RATIOS[i]);
      repeat (20) @(posedge ref_clk);
      #1 c0 = ce_count;
      repeat (n) @(posedge ref_clk);
      #1 check(ce_count - c0, 8'h06);
    end
  endtask

  task automatic t_por();
    @(posedge ref_clk) power_on_reset_n <= 1'b0;
    #1 check(8'({power_on_sync_reset_n, test_state_machine_reset_n,
      trace_bus_reset_n}), 8'h03);
    @(posedge ref_clk) power_on_reset_n <= 1'b1;
    @(posedge ref_clk) #1 check(8'(power_on_sync_reset_n), 8'h00);
    @(posedge ref_clk) #1 check(8'(power_on_sync_reset_n), 8'h01);
    @(posedge ref_clk) test_reset_src_n <= 1'b0;
    #1 check(8'({power_on_sync_reset_n, test_state_machine_reset_n}),
      8'h02);
    @(posedge ref_clk) test_reset_src_n <= 1'b1;
  endtask

  task automatic t_sys();
    @(posedge ref_clk) interconnect_reset_n <= 1'b0;
    #1 check(8'({access_port_sys_reset_n,
      system_peripheral_reset_n, bus_trace_unit_reset_n,
      access_port_reset_n}), 8'h03);
    @(posedge ref_clk) interconnect_reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    bus_trace_src_reset_n <= 1'b0;
    #1 check(8'({access_port_sys_reset_n,
      system_peripheral_reset_n, bus_trace_unit_reset_n,
      access_port_reset_n}), 8'h0D);
    @(posedge ref_clk) bus_trace_src_reset_n <= 1'b1;
  endtask

  // request held three cycles: the extra cycles fall in the hold
  task automatic t_scan(input logic [1:0] sel);
    int nc = 0;
    int ns = 0;
    @(posedge ref_clk) {scan_subsys_reset_req, scan_tap_reset_req} <= sel;
    for (int i = 0; i < 25; i++) begin
      @(posedge ref_clk);
      if (i == 2) {scan_subsys_reset_req, scan_tap_reset_req} <= 2'b00;
      #1 nc += int'(!scan_chain_controller_reset_n);
      ns += int'(!scan_subsystem_reset_n);
    end
    check(8'(nc), sel[0] ? 8'(SCAN_HOLD_CYC) : 8'h00);
    check(8'(ns), sel[1] ? 8'(SCAN_HOLD_CYC) : 8'h00);
  endtask

  task automatic t_xing();
    @(posedge ref_clk) {sys_to_dap, dap_to_sys} <= 8'hA5;
    @(posedge ref_clk) #1 check({sys_to_dap_sync, dap_to_sys_sync},
      8'h00);
    @(posedge ref_clk) #1 check({sys_to_dap_sync, dap_to_sys_sync},
      8'hA5);
  endtask

  // ****************************************************************
  // clock, timeout and main sequence
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    #1 {rstn, power_on_reset_n, test_reset_src_n} = 3'b000;
    {interconnect_reset_n, bus_trace_src_reset_n} = 2'b00;
    {scan_tap_reset_req, scan_subsys_reset_req} = 2'b00;
    trace_clock_shared = 1'b1;
    debug_bus_ratio = 4'h1;
    {sys_to_dap, dap_to_sys} = 8'h00;
    n_fail = 0;
    tests_run = 0;
    repeat (8) @(posedge ref_clk);
    {rstn, power_on_reset_n, test_reset_src_n} <= 3'b111;
    {interconnect_reset_n, bus_trace_src_reset_n} <= 2'b11;
    repeat (4) @(posedge ref_clk);
    t_debug_reset(1'b1);
    t_debug_reset(1'b0);
    t_ratio();
    t_por();
    t_sys();
    t_scan(2'b01);
    t_scan(2'b10);
    t_scan(2'b11);
    t_xing();
    complete_run();
  end
endmodule // dcr_top_tb_top
